//--- rtl/msipu_pkg.sv
// package: register map, field positions and types of the interrupt block
package msipu_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CORE_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_CORE_MASK     = 8'h04;
    localparam logic [7:0] ADDR_DROP_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_DROP_MASK     = 8'h0C;
    localparam logic [7:0] ADDR_SEQ_THRESHOLD = 8'h10;
    localparam logic [7:0] ADDR_TARGET_LOW    = 8'h14;
    localparam logic [7:0] ADDR_TARGET_HIGH   = 8'h18;
    localparam logic [7:0] ADDR_TARGET_CTX    = 8'h1C;
    localparam logic [7:0] ADDR_UPDATE_EN     = 8'h20;
    localparam logic [7:0] ADDR_UPDATE_STAT   = 8'h24;
    // crypto core status bit positions
    localparam int BIT_INPUT_ERR   = 0;
    localparam int BIT_OUTPUT_ERR  = 1;
    localparam int BIT_PROC_ERR    = 2;
    localparam int BIT_CTX_ERR     = 3;
    localparam int BIT_SEQ_THRESH  = 4;
    localparam int BIT_SEQ_ROLL    = 5;
    localparam int BIT_FATAL_ERR   = 14;
    // drop status bit positions
    localparam int BIT_IG_CLASS    = 0;
    localparam int BIT_IG_CONSIST  = 1;
    localparam int BIT_IG_POST     = 2;
    localparam int BIT_IG_MTU      = 3;
    localparam int BIT_EG_CLASS    = 8;
    localparam int BIT_EG_POST     = 9;
    localparam int BIT_EG_MTU      = 10;
    // reset values
    localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
    localparam logic [31:0] RST_THRESHOLD  = 32'hF000_0000;
    // core and drop status bits that exist
    localparam logic [31:0] CORE_IMPL_MASK = 32'h0000_403F;
    localparam logic [31:0] DROP_IMPL_MASK = 32'h0000_070F;
    localparam int CTX_W = 8;
    // one wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } msipu_wb_req_t;
    // update engine states
    typedef enum logic [3:0] {
        MSIPU_IDLE  = 4'h1,
        MSIPU_READ  = 4'h2,
        MSIPU_WRITE = 4'h4,
        MSIPU_DONE  = 4'h8
    } msipu_upd_state_t;
endpackage

//--- rtl/msipu_pn_update.sv
// module: ingress packet-number forward update engine
`timescale 1ns/10ps
`default_nettype none
module msipu_pn_update (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // request from registers
    input  wire logic              start_i,
    input  wire logic [63:0]       target_i,
    input  wire logic [msipu_pkg::CTX_W-1:0] ctx_i,
    // transform record port
    output logic                   rec_rd_o,
    output logic                   rec_wr_o,
    output logic [msipu_pkg::CTX_W-1:0] rec_ctx_o,
    output logic [63:0]            rec_wdata_o,
    input  wire logic              rec_ack_i,
    input  wire logic [63:0]       rec_rdata_i,
    // completion
    output logic                   done_o,
    output logic                   skipped_o
);
    msipu_pkg::msipu_upd_state_t state;    // current state
    msipu_pkg::msipu_upd_state_t next_state;
    logic [63:0]                 current;  // number read from the record
    wire                         is_behind; // record below target
    assign is_behind = (current < target_i);
    // next state decode
    always_comb begin
        next_state = state;
        case (state)
            msipu_pkg::MSIPU_IDLE:  if (start_i) next_state = msipu_pkg::MSIPU_READ;
            msipu_pkg::MSIPU_READ:  if (rec_ack_i) next_state = msipu_pkg::MSIPU_WRITE;
            msipu_pkg::MSIPU_WRITE: begin
                // never move the number backwards [RQ18]
                if (!is_behind) next_state = msipu_pkg::MSIPU_DONE;
                else if (rec_ack_i) next_state = msipu_pkg::MSIPU_DONE;
            end
            msipu_pkg::MSIPU_DONE:  next_state = msipu_pkg::MSIPU_IDLE;
            default:                next_state = msipu_pkg::MSIPU_IDLE;
        endcase
    end
    // state and result registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state       <= msipu_pkg::MSIPU_IDLE;
            current     <= 64'h0;
            rec_ctx_o   <= '0;
            rec_wdata_o <= 64'h0;
            skipped_o   <= 1'b0;
        end else begin
            state <= next_state;
            if (state == msipu_pkg::MSIPU_IDLE && start_i) begin
                rec_ctx_o   <= ctx_i;
                rec_wdata_o <= target_i; // raise to target [RQ16]
            end
            if (state == msipu_pkg::MSIPU_READ && rec_ack_i) begin
                current <= rec_rdata_i;
            end
            if (state == msipu_pkg::MSIPU_WRITE) begin
                skipped_o   <= !is_behind; // [RQ18]
            end
        end
    end
    // read and done strobes are decoded from the state register; the write also needs is_behind
    assign rec_rd_o = (state == msipu_pkg::MSIPU_READ);
    assign rec_wr_o = (state == msipu_pkg::MSIPU_WRITE) && is_behind; // [RQ16]
    assign done_o   = (state == msipu_pkg::MSIPU_DONE); // [RQ17]
endmodule
`default_nettype wire

//--- rtl/msipu_top.sv
// module: security engine interrupt sources and ingress pn update
// Operation
// [RQ1] five ingress sources, four egress sources
// [RQ2] read status, write same bits clears
// [RQ3] bit 0 set on short malformed packet
// [RQ4] bit 1 output error, bit 14 fatal
// [RQ5] bit 2 set on processing failure
// [RQ6] bit 3 set on faulty transform record
// [RQ7] bit 4 threshold warning, processing continues
// [RQ8] bit 5 set on egress number rollover
// [RQ9] software programs threshold, enables interrupt
// [RQ10] software disables, clears, rekeys, reenables
// [RQ11] classification drop raises its interrupt
// [RQ12] ingress consistency drop raises its interrupt
// [RQ13] other post-processing drops raise interrupt
// [RQ14] mtu drop raises dedicated interrupt
// [RQ15] host writes target, context, then enable
// [RQ16] raise context number to requested value
// [RQ17] enable clears itself after record write
// [RQ18] no write when record already ahead
// [RQ19] overrun statistic reported zero by software
// [RQ20] software sums octet counters per sa type
// [RQ21] software sums too-long counter over sas
// [RQ22] software reads combined egress counter
// [RQ23] outputs follow pending unmasked status level
`timescale 1ns/10ps
`default_nettype none
module msipu_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // crypto core event pulses, one per status bit except bit 4
    input  wire logic        ev_input_err_i,
    input  wire logic        ev_output_err_i,
    input  wire logic        ev_proc_err_i,
    input  wire logic        ev_ctx_err_i,
    input  wire logic        ev_fatal_err_i,
    input  wire logic        ev_seq_roll_i,
    // egress number probed against threshold
    input  wire logic        eg_seq_valid_i,
    input  wire logic [31:0] eg_seq_num_i,
    // drop event pulses
    input  wire logic        ig_drop_class_i,
    input  wire logic        ig_drop_consist_i,
    input  wire logic        ig_drop_post_i,
    input  wire logic        ig_drop_mtu_i,
    input  wire logic        eg_drop_class_i,
    input  wire logic        eg_drop_post_i,
    input  wire logic        eg_drop_mtu_i,
    // transform record port
    output logic             rec_rd_o,
    output logic             rec_wr_o,
    output logic [7:0]       rec_ctx_o,
    output logic [63:0]      rec_wdata_o,
    input  wire logic        rec_ack_i,
    input  wire logic [63:0] rec_rdata_i,
    // interrupt levels: ingress five, egress four
    output logic             ig_core_irq_o,
    output logic             ig_class_irq_o,
    output logic             ig_consist_irq_o,
    output logic             ig_post_irq_o,
    output logic             ig_mtu_irq_o,
    output logic             eg_core_irq_o,
    output logic             eg_class_irq_o,
    output logic             eg_post_irq_o,
    output logic             eg_mtu_irq_o
);
    // register storage
    logic [31:0] core_status;      // crypto core w1c status
    logic [31:0] core_mask;        // enables for core status
    logic [31:0] drop_status;      // drop w1c status
    logic [31:0] drop_mask;        // enables for drop status
    logic [31:0] seq_threshold;    // sequence number threshold
    logic [31:0] target_low;       // target number low word
    logic [31:0] target_high;      // target number high word
    logic [7:0]  target_ctx;       // update target context
    logic        update_en;        // self-clearing update request
    logic        update_skipped;   // last update found record at or above target
    // engine handshake
    logic        upd_done;
    logic        upd_skip;
    logic        upd_start;
    // byte lane merge, used by the masks, threshold, target words and the w1c clear mask
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction
    // bus decode
    wire         bus_req;          // request not yet answered
    wire         wr_req;
    wire [31:0]  wr_mask;          // bits covered by byte enables
    wire         hit_core, hit_cmask, hit_drop, hit_dmask, hit_thr;
    wire         hit_low, hit_high, hit_ctx, hit_en, hit_stat;
    assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_req    = bus_req && wb_we_i;
    assign wr_mask   = lane_merge(32'h0, 32'hFFFF_FFFF, wb_sel_i);
    assign hit_core  = (wb_adr_i == msipu_pkg::ADDR_CORE_STATUS);
    assign hit_cmask = (wb_adr_i == msipu_pkg::ADDR_CORE_MASK);
    assign hit_drop  = (wb_adr_i == msipu_pkg::ADDR_DROP_STATUS);
    assign hit_dmask = (wb_adr_i == msipu_pkg::ADDR_DROP_MASK);
    assign hit_thr   = (wb_adr_i == msipu_pkg::ADDR_SEQ_THRESHOLD);
    assign hit_low   = (wb_adr_i == msipu_pkg::ADDR_TARGET_LOW);
    assign hit_high  = (wb_adr_i == msipu_pkg::ADDR_TARGET_HIGH);
    assign hit_ctx   = (wb_adr_i == msipu_pkg::ADDR_TARGET_CTX);
    assign hit_en    = (wb_adr_i == msipu_pkg::ADDR_UPDATE_EN);
    assign hit_stat  = (wb_adr_i == msipu_pkg::ADDR_UPDATE_STAT);
    // event vectors
    wire [31:0]  core_set;         // new core status events
    wire [31:0]  drop_set;         // new drop events
    wire         thr_cross;        // egress number beyond threshold
    assign thr_cross = eg_seq_valid_i && (eg_seq_num_i > seq_threshold); // [RQ7]
    assign core_set = (32'(ev_input_err_i)  << msipu_pkg::BIT_INPUT_ERR)  // [RQ3]
                    | (32'(ev_output_err_i) << msipu_pkg::BIT_OUTPUT_ERR) // [RQ4]
                    | (32'(ev_fatal_err_i)  << msipu_pkg::BIT_FATAL_ERR)  // [RQ4]
                    | (32'(ev_proc_err_i)   << msipu_pkg::BIT_PROC_ERR)   // [RQ5]
                    | (32'(ev_ctx_err_i)    << msipu_pkg::BIT_CTX_ERR)    // [RQ6]
                    | (32'(thr_cross)       << msipu_pkg::BIT_SEQ_THRESH) // [RQ7]
                    | (32'(ev_seq_roll_i)   << msipu_pkg::BIT_SEQ_ROLL);  // [RQ8]
    assign drop_set = (32'(ig_drop_class_i)   << msipu_pkg::BIT_IG_CLASS)   // [RQ11]
                    | (32'(ig_drop_consist_i) << msipu_pkg::BIT_IG_CONSIST) // [RQ12]
                    | (32'(ig_drop_post_i)    << msipu_pkg::BIT_IG_POST)    // [RQ13]
                    | (32'(ig_drop_mtu_i)     << msipu_pkg::BIT_IG_MTU)     // [RQ14]
                    | (32'(eg_drop_class_i)   << msipu_pkg::BIT_EG_CLASS)   // [RQ11]
                    | (32'(eg_drop_post_i)    << msipu_pkg::BIT_EG_POST)    // [RQ13]
                    | (32'(eg_drop_mtu_i)     << msipu_pkg::BIT_EG_MTU);    // [RQ14]
    // w1c: writing back the read value clears those bits
    wire [31:0]  core_clr;
    wire [31:0]  drop_clr;
    assign core_clr = (wr_req && hit_core) ? (wb_dat_i & wr_mask) : 32'h0; // [RQ2]
    assign drop_clr = (wr_req && hit_drop) ? (wb_dat_i & wr_mask) : 32'h0; // [RQ2]
    // a new event wins over a same-cycle clear
    wire [31:0]  next_core_status;
    wire [31:0]  next_drop_status;
    assign next_core_status = ((core_status & ~core_clr) | core_set)
                            & msipu_pkg::CORE_IMPL_MASK; // [RQ2]
    assign next_drop_status = ((drop_status & ~drop_clr) | drop_set)
                            & msipu_pkg::DROP_IMPL_MASK;
    // pending unmasked conditions
    wire [31:0]  core_pend;
    wire [31:0]  drop_pend;
    assign core_pend = next_core_status & core_mask;
    assign drop_pend = next_drop_status & drop_mask;
    // read data select; unmapped addresses read zero
    wire [31:0]  rd_data;
    assign rd_data = hit_core  ? core_status   :
                     hit_cmask ? core_mask     :
                     hit_drop  ? drop_status   :
                     hit_dmask ? drop_mask     :
                     hit_thr   ? seq_threshold :
                     hit_low   ? target_low    :
                     hit_high  ? target_high   :
                     hit_ctx   ? {24'h0, target_ctx} :
                     hit_en    ? {31'h0, update_en} :
                     hit_stat  ? {31'h0, update_skipped} :
                                 32'h0;
    // engine starts on the cycle the enable is first written
    wire         en_write;
    assign en_write  = wr_req && hit_en && wb_sel_i[0] && wb_dat_i[0]
                     && !update_en;
    assign upd_start = en_write; // [RQ15]
    // ack one cycle after the request, one cycle long
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= msipu_pkg::RST_ZERO;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : msipu_pkg::RST_ZERO;
        end
    end
    // status registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_status <= msipu_pkg::RST_ZERO;
            drop_status <= msipu_pkg::RST_ZERO;
        end else begin
            core_status <= next_core_status;
            drop_status <= next_drop_status;
        end
    end
    // software-written configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_mask     <= msipu_pkg::RST_ZERO;
            drop_mask     <= msipu_pkg::RST_ZERO;
            seq_threshold <= msipu_pkg::RST_THRESHOLD;
            target_low    <= msipu_pkg::RST_ZERO;
            target_high   <= msipu_pkg::RST_ZERO;
            target_ctx    <= 8'h00;
        end else if (wr_req) begin
            if (hit_cmask) core_mask <= lane_merge(core_mask, wb_dat_i, wb_sel_i);
            if (hit_dmask) drop_mask <= lane_merge(drop_mask, wb_dat_i, wb_sel_i);
            if (hit_thr) seq_threshold <= lane_merge(seq_threshold, wb_dat_i,
                                                     wb_sel_i);
            // target is locked while an update runs
            if (hit_low && !update_en) target_low <= lane_merge(target_low,
                                                     wb_dat_i, wb_sel_i);
            if (hit_high && !update_en) target_high <= lane_merge(target_high,
                                                      wb_dat_i, wb_sel_i);
            if (hit_ctx && !update_en && wb_sel_i[0]) target_ctx <= wb_dat_i[7:0];
        end
    end
    // update enable: software sets, engine clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            update_en      <= 1'b0;
            update_skipped <= 1'b0;
        end else begin
            if (upd_done) begin
                update_en      <= 1'b0; // [RQ17]
                update_skipped <= upd_skip; // [RQ18]
            end else if (en_write) begin
                update_en <= 1'b1;
            end
        end
    end
    // registered interrupt levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ig_core_irq_o    <= 1'b0;
            ig_class_irq_o   <= 1'b0;
            ig_consist_irq_o <= 1'b0;
            ig_post_irq_o    <= 1'b0;
            ig_mtu_irq_o     <= 1'b0;
            eg_core_irq_o    <= 1'b0;
            eg_class_irq_o   <= 1'b0;
            eg_post_irq_o    <= 1'b0;
            eg_mtu_irq_o     <= 1'b0;
        end else begin
            // the core status is shared; both directions see it [RQ1]
            ig_core_irq_o    <= |core_pend; // [RQ23]
            eg_core_irq_o    <= |core_pend; // [RQ23]
            ig_class_irq_o   <= drop_pend[msipu_pkg::BIT_IG_CLASS]; // [RQ11]
            ig_consist_irq_o <= drop_pend[msipu_pkg::BIT_IG_CONSIST]; // [RQ12]
            ig_post_irq_o    <= drop_pend[msipu_pkg::BIT_IG_POST]; // [RQ13]
            ig_mtu_irq_o     <= drop_pend[msipu_pkg::BIT_IG_MTU]; // [RQ14]
            eg_class_irq_o   <= drop_pend[msipu_pkg::BIT_EG_CLASS]; // [RQ11]
            eg_post_irq_o    <= drop_pend[msipu_pkg::BIT_EG_POST]; // [RQ13]
            eg_mtu_irq_o     <= drop_pend[msipu_pkg::BIT_EG_MTU]; // [RQ14]
        end
    end
    // forward update engine
    msipu_pn_update u_pn_update (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .start_i     (upd_start),
        .target_i    ({target_high, target_low}),
        .ctx_i       (target_ctx),
        .rec_rd_o    (rec_rd_o),
        .rec_wr_o    (rec_wr_o),
        .rec_ctx_o   (rec_ctx_o),
        .rec_wdata_o (rec_wdata_o),
        .rec_ack_i   (rec_ack_i),
        .rec_rdata_i (rec_rdata_i),
        .done_o      (upd_done),
        .skipped_o   (upd_skip)
    );
endmodule
`default_nettype wire

//--- test/msipu_assertions.sv
// checker: bus handshake, interrupt levels and record access
`timescale 1ns/10ps
`default_nettype none
module msipu_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    // drops and interrupts
    input wire logic eg_drop_post_i,
    input wire logic ig_core_irq_o,
    input wire logic eg_core_irq_o,
    input wire logic eg_post_irq_o,
    input wire logic ig_mtu_irq_o,
    // record port
    input wire logic rec_rd_o,
    input wire logic rec_wr_o,
    input wire logic rec_ack_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bus write, the only way to clear status
    wire wr_req = wb_cyc_i && wb_stb_i && wb_we_i;
    // record accesses end on the ack edge
    sequence s_rd_end; rec_rd_o && rec_ack_i; endsequence
    sequence s_wr_end; rec_wr_o && rec_ack_i; endsequence
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_core_same; ig_core_irq_o == eg_core_irq_o; endproperty
    property p_post_hold;
        eg_drop_post_i && eg_post_irq_o && !(wb_cyc_i && wb_stb_i)
            |=> eg_post_irq_o;
    endproperty
    property p_mtu_fall; $fell(ig_mtu_irq_o) |-> $past(wr_req); endproperty
    property p_rd_hold; rec_rd_o && !rec_ack_i |=> rec_rd_o; endproperty
    property p_wr_hold; rec_wr_o && !rec_ack_i |=> rec_wr_o; endproperty
    property p_rd_close; s_rd_end |=> !rec_rd_o; endproperty
    property p_wr_close; s_wr_end |=> !rec_wr_o ##1 !(rec_rd_o || rec_wr_o); endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("bus ack missing");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus ack too long");
    a_core_same: assert property (p_core_same)
        else $error("core irq outputs differ");
    a_post_hold: assert property (p_post_hold)
        else $error("post drop irq lost");
    a_mtu_fall: assert property (p_mtu_fall)
        else $error("mtu irq fell without write");
    a_rd_hold: assert property (p_rd_hold)
        else $error("record read dropped early");
    a_wr_hold: assert property (p_wr_hold)
        else $error("record write dropped early");
    a_rd_close: assert property (p_rd_close)
        else $error("record read not closed");
    a_wr_close: assert property (p_wr_close)
        else $error("record write not closed");
endmodule
bind msipu_top msipu_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_ack_o, .eg_drop_post_i, .ig_core_irq_o, .eg_core_irq_o,
    .eg_post_irq_o, .ig_mtu_irq_o, .rec_rd_o, .rec_wr_o, .rec_ack_i);
`default_nettype wire

//--- test/tb_top.sv
// testbench: registers, interrupt sources and number update
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk_i = 1'b0;      // core clock
    logic        rst_i = 1'b1;      // sync reset
    msipu_pkg::msipu_wb_req_t req = '0; // bus request
    logic [31:0] wb_dat_o;          // read data
    logic        wb_ack_o;          // bus ack
    logic [5:0]  ev = '0;           // core event pulses
    logic        sq_v = 1'b0;       // threshold probe valid
    logic [31:0] sq_n = '0;         // threshold probe number
    logic [6:0]  dr = '0;           // drop pulses
    logic [6:0]  irq;               // drop interrupts
    logic [1:0]  core;              // core interrupts
    logic        rd;                // record read
    logic        wr;                // record write
    logic        ack = 1'b0;        // record ack
    logic [7:0]  rctx;              // record context
    logic [7:0]  seen_ctx = '0;     // context seen on read
    logic [63:0] wdat;              // record write data
    logic [63:0] rdata;             // record read data
    logic [63:0] cur = '0;          // record contents
    logic [2:0]  dly = 3'h1;        // ack delay
    int          mismatches = 0;
    int          n_tests = 0;
    int          n_wr = 0;          // record writes seen
    // stale data is inverted so a late sample is caught
    assign rdata = ack ? cur : ~cur;
    always #10 clk_i = ~clk_i;
    msipu_top uut (
        .clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
        .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ev_input_err_i(ev[0]), .ev_output_err_i(ev[1]),
        .ev_proc_err_i(ev[2]), .ev_ctx_err_i(ev[3]),
        .ev_fatal_err_i(ev[4]), .ev_seq_roll_i(ev[5]),
        .eg_seq_valid_i(sq_v), .eg_seq_num_i(sq_n),
        .ig_drop_class_i(dr[0]), .ig_drop_consist_i(dr[1]),
        .ig_drop_post_i(dr[2]), .ig_drop_mtu_i(dr[3]),
        .eg_drop_class_i(dr[4]), .eg_drop_post_i(dr[5]),
        .eg_drop_mtu_i(dr[6]),
        .rec_rd_o(rd), .rec_wr_o(wr), .rec_ctx_o(rctx),
        .rec_wdata_o(wdat), .rec_ack_i(ack), .rec_rdata_i(rdata),
        .ig_core_irq_o(core[0]), .eg_core_irq_o(core[1]),
        .ig_class_irq_o(irq[0]), .ig_consist_irq_o(irq[1]),
        .ig_post_irq_o(irq[2]), .ig_mtu_irq_o(irq[3]),
        .eg_class_irq_o(irq[4]), .eg_post_irq_o(irq[5]),
        .eg_mtu_irq_o(irq[6]));
    // record store, acks after 2..5 cycles
    always @(posedge clk_i) begin
        ack <= 1'b0;
        if (ack && wr) begin
            cur <= wdat;
            n_wr <= n_wr + 1;
        end
        if (rd)
            seen_ctx <= rctx;
        if ((rd || wr) && !ack) begin
            if (dly != 3'h0)
                dly <= dly - 3'h1;
            else begin
                ack <= 1'b1;
                dly <= 3'($urandom % 4) + 3'h1;
            end
        end
    end
    // expected status bit of each input
    function automatic int core_bit(int i);
        return (i == 4) ? 14 : i;
    endfunction
    function automatic int drop_bit(int i);
        return (i < 4) ? i : i + 4;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, a, 4'hF, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        req <= '0;
        @(posedge clk_i);
        if (n >= 40)
            mismatches++;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, '0, q);
        chk(q, e);
    endtask
    // one cycle pulse: 0..5 core event, 6..12 drop, else probe
    task automatic kick(input int k, input logic [31:0] n);
        @(posedge clk_i);
        if (k < 6)
            ev[k] <= 1'b1;
        else if (k < 13)
            dr[k-6] <= 1'b1;
        else begin
            sq_v <= 1'b1;
            sq_n <= n;
        end
        @(posedge clk_i);
        ev <= '0;
        dr <= '0;
        sq_v <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        logic [63:0] base;
        logic [63:0] tgt;
        logic [31:0] q;
        logic [31:0] thr;
        logic [7:0]  ctx;
        int          nw;
        int          n;
        void'($urandom(32));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(msipu_pkg::ADDR_SEQ_THRESHOLD, 32'hF000_0000);
        wr_reg(8'h3C, $urandom);
        rd_chk(8'h3C, 32'h0);
        $display("map done");
        wr_reg(msipu_pkg::ADDR_CORE_MASK, 32'h0000_403F);
        for (int i = 0; i < 6; i++) begin
            kick(i, '0);
            chk(core, 2'h3);
            wr_reg(msipu_pkg::ADDR_CORE_STATUS, ~(32'h1 << core_bit(i)));
            rd_chk(msipu_pkg::ADDR_CORE_STATUS, 32'h1 << core_bit(i));
            wr_reg(msipu_pkg::ADDR_CORE_STATUS, 32'h1 << core_bit(i));
            rd_chk(msipu_pkg::ADDR_CORE_STATUS, 32'h0);
            chk(core, 2'h0);
        end
        thr = $urandom & 32'hFFFF_FFFE;
        wr_reg(msipu_pkg::ADDR_SEQ_THRESHOLD, thr);
        kick(13, thr);
        rd_chk(msipu_pkg::ADDR_CORE_STATUS, 32'h0);
        kick(13, thr + 32'h1);
        rd_chk(msipu_pkg::ADDR_CORE_STATUS, 32'h10);
        wr_reg(msipu_pkg::ADDR_CORE_STATUS, 32'h10);
        $display("core status done");
        kick(6, '0);
        chk(irq, 7'h0);
        wr_reg(msipu_pkg::ADDR_DROP_MASK, 32'h0000_070F);
        chk(irq, 7'h1);
        wr_reg(msipu_pkg::ADDR_DROP_STATUS, 32'h1);
        for (int i = 0; i < 7; i++) begin
            kick(i + 6, '0);
            chk(irq, 7'h1 << i);
            rd_chk(msipu_pkg::ADDR_DROP_STATUS, 32'h1 << drop_bit(i));
            wr_reg(msipu_pkg::ADDR_DROP_STATUS, 32'h1 << drop_bit(i));
            chk(irq, 7'h0);
        end
        $display("drops done");
        for (int i = 0; i < 6; i++) begin
            base = {$urandom, $urandom};
            tgt = (i == 0) ? base + 64'h1 : (i == 1) ? base :
                  (i == 2) ? base - 64'h1 : {$urandom, $urandom};
            cur = base;
            ctx = 8'($urandom);
            nw = n_wr;
            wr_reg(msipu_pkg::ADDR_TARGET_LOW, tgt[31:0]);
            wr_reg(msipu_pkg::ADDR_TARGET_HIGH, tgt[63:32]);
            wr_reg(msipu_pkg::ADDR_TARGET_CTX, {24'h0, ctx});
            wr_reg(msipu_pkg::ADDR_UPDATE_EN, 32'h1);
            n = 0;
            do begin
                wb(1'b0, msipu_pkg::ADDR_UPDATE_EN, '0, q);
                n++;
            end while (q[0] !== 1'b0 && n < 50);
            chk(q, 32'h0);
            chk(cur, (base < tgt) ? tgt : base);
            chk(n_wr - nw, (base < tgt) ? 1 : 0);
            rd_chk(msipu_pkg::ADDR_UPDATE_STAT, {31'h0, base >= tgt});
            chk(seen_ctx, ctx);
        end
        $display("update done");
        final_report;
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        final_report;
    end
endmodule
`default_nettype wire
